// ===== design/sir_pkg.sv
// Summary of operation
// RL1: an opcode 12h command block is taken as an inquiry and answered with data.
// RL2: host sets allocation 07h, 0Eh, 42h per page, up to FFh for standard.
// RL3: at most 106 standard, 7 supported, 14 serial, 66 identification bytes returned.
// RL4: select bit 0 returns standard data, page code ignored.
// RL5: select bit 1 with page 00h returns the supported pages list.
// RL6: identification page 83h is supported beside supported-pages and serial pages.
// RL7: standard bytes 0, 2, 3, 4 carry type, versions, format and additional length.
// RL8: standard bytes 16 to 31 hold product name, right padded with spaces.
// RL9: standard bytes 36 to 43 hold the eight-character firmware image tag.
// RL10: supported page holds type, page code, reserved and page length in bytes 0-3.
// RL11: supported page lists one page code in each of bytes 4, 5, 6.
// RL12: qualifier bits 7 to 5 of byte 0 read 0.
// RL13: device type bits 4 to 0 of byte 0 read 01h.
// RL14: supported page length is 03h, listing 00h, 80h, 83h.
// RL15: identification page carries page length 3Eh.
// RL16: transfer ends after min of allocation and full response length (page length plus header); zero sends nothing.
// RL17: select bit 1 with unknown page gives an illegal request check condition.
package sir_pkg;
    localparam logic [7:0] SIR_OP_INQUIRY = 8'h12;
    localparam logic [7:0] SIR_PG_SUP = 8'h00;
    localparam logic [7:0] SIR_PG_SER = 8'h80;
    localparam logic [7:0] SIR_PG_ID = 8'h83;
    localparam logic [7:0] SIR_LEN_STD = 8'h6A;
    localparam logic [7:0] SIR_LEN_SUP = 8'h07;
    localparam logic [7:0] SIR_LEN_SER = 8'h0E;
    localparam logic [7:0] SIR_LEN_ID = 8'h42;
    localparam logic [2:0] SIR_QUAL = 3'h0;
    localparam logic [4:0] SIR_DTYPE = 5'h01;
    localparam logic [7:0] SIR_SUP_PLEN = 8'h03;
    localparam logic [7:0] SIR_SER_PLEN = 8'h0A;
    localparam logic [7:0] SIR_ID_PLEN = 8'h3E;
    localparam logic [7:0] SIR_STD_ADDLEN = 8'h65;
    localparam logic [7:0] SIR_ZERO = 8'h00;
    localparam logic [7:0] SIR_SPACE = 8'h20;
    localparam logic [7:0] SIR_B_HDR = 8'h00;
    localparam logic [7:0] SIR_B_PAGE = 8'h01;
    localparam logic [7:0] SIR_B_RSV = 8'h02;
    localparam logic [7:0] SIR_B_PLEN = 8'h03;
    localparam logic [7:0] SIR_B_VER = 8'h02;
    localparam logic [7:0] SIR_B_FMT = 8'h03;
    localparam logic [7:0] SIR_B_ADDLEN = 8'h04;
    localparam logic [7:0] SIR_B_LIST0 = 8'h04;
    localparam logic [7:0] SIR_B_LIST1 = 8'h05;
    localparam logic [7:0] SIR_B_LIST2 = 8'h06;
    localparam logic [7:0] SIR_B_NAME_LO = 8'h10;
    localparam logic [7:0] SIR_B_NAME_HI = 8'h1F;
    localparam logic [7:0] SIR_B_TAG_LO = 8'h24;
    localparam logic [7:0] SIR_B_TAG_HI = 8'h2B;
    localparam logic [7:0] SIR_MEM_STD = 8'h00;
    localparam logic [7:0] SIR_MEM_SER = 8'h80;
    localparam logic [7:0] SIR_MEM_ID = 8'hA0;
    localparam logic [7:0] SIR_REG_CTRL = 8'h00;
    localparam logic [7:0] SIR_REG_STATUS = 8'h04;
    localparam logic [7:0] SIR_REG_CDB_LO = 8'h08;
    localparam logic [7:0] SIR_REG_CDB_HI = 8'h0C;
    localparam logic [7:0] SIR_REG_MEM_ADDR = 8'h10;
    localparam logic [7:0] SIR_REG_MEM_DATA = 8'h14;
    localparam int SIR_ST_BUSY = 0;
    localparam int SIR_ST_DONE = 1;
    localparam int SIR_ST_CHECK = 2;
    localparam int SIR_ST_BADOP = 3;
    localparam int SIR_ST_CNT = 8;
    localparam logic [1:0] SIR_RESP_OK = 2'h0;
    localparam logic [1:0] SIR_RESP_ERR = 2'h2;
    typedef enum logic [3:0] {
        SIR_IDLE = 4'h1,
        SIR_FETCH = 4'h2,
        SIR_PUSH = 4'h4,
        SIR_FINISH = 4'h8
    } sir_state_t;
    typedef enum logic [1:0] {
        SIR_SEL_STD = 2'h0,
        SIR_SEL_SUP = 2'h1,
        SIR_SEL_SER = 2'h2,
        SIR_SEL_ID = 2'h3
    } sir_sel_t;
endpackage

// ===== design/sir_fifo.sv
`timescale 1ns/100ps
module sir_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = cnt_reg != (AW+1)'(DEPTH);
    assign out_valid = cnt_reg != '0;
    assign out_data = mem_reg[rd_reg];
    // plain counter; depth need not be a power of two
    function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
        step = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction
    always_ff @(posedge clock) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) wr_reg <= step(wr_reg);
            if (pop) rd_reg <= step(rd_reg);
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ===== design/sir_mem.sv
`timescale 1ns/100ps
module sir_mem #(
    parameter int AW = 8
) (
    input wire logic clock,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem_reg [2**AW];
    // read data registered: one cycle from address to data
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
        rd_data <= mem_reg[rd_addr];
    end
endmodule

// ===== design/sir_top.sv
`timescale 1ns/100ps
module sir_top #(
    parameter logic [7:0] VERSION_BYTE = 8'h02,
    parameter logic [7:0] FORMAT_BYTE = 8'h02,
    parameter logic [63:0] FIRMWARE_IMAGE_TAG = 64'h494D_4730_3030_3031,
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [7:0] resp_data,
    output logic resp_last,
    output logic resp_valid,
    input wire logic resp_ready
);
    // firmware image tag default is arbitrary
    sir_pkg::sir_state_t state_reg;
    sir_pkg::sir_state_t state_next;
    sir_pkg::sir_sel_t sel_reg;
    logic [31:0] cdb_lo_reg;
    logic [15:0] cdb_hi_reg;
    logic [7:0] mem_addr_reg;
    logic [7:0] idx_reg;
    logic [7:0] limit_reg;
    logic [7:0] sent_reg;
    logic done_reg;
    logic check_reg;
    logic badop_reg;
    logic aw_full_reg;
    logic w_full_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [7:0] mem_rd;
    logic fifo_in_ready;
    logic [8:0] fifo_out;

    // command block fields, six-byte form
    wire [7:0] cdb_opcode = cdb_lo_reg[7:0];
    wire cdb_evpd = cdb_lo_reg[8];
    wire [7:0] cdb_page = cdb_lo_reg[23:16];
    wire [7:0] cdb_alloc = cdb_hi_reg[7:0];

    function automatic logic [7:0] min8(input logic [7:0] a, input logic [7:0] b);
        min8 = (a < b) ? a : b;
    endfunction

    function automatic logic [7:0] sel_len(input sir_pkg::sir_sel_t s);
        case (s)
            sir_pkg::SIR_SEL_SUP: sel_len = sir_pkg::SIR_LEN_SUP;
            sir_pkg::SIR_SEL_SER: sel_len = sir_pkg::SIR_LEN_SER;
            sir_pkg::SIR_SEL_ID: sel_len = sir_pkg::SIR_LEN_ID;
            default: sel_len = sir_pkg::SIR_LEN_STD;
        endcase
    endfunction

    function automatic logic [7:0] sel_base(input sir_pkg::sir_sel_t s);
        case (s)
            sir_pkg::SIR_SEL_SER: sel_base = sir_pkg::SIR_MEM_SER;
            sir_pkg::SIR_SEL_ID: sel_base = sir_pkg::SIR_MEM_ID;
            default: sel_base = sir_pkg::SIR_MEM_STD;
        endcase
    endfunction

    // page decode at start
    wire page_ok = !cdb_evpd || cdb_page == sir_pkg::SIR_PG_SUP ||
        cdb_page == sir_pkg::SIR_PG_SER || cdb_page == sir_pkg::SIR_PG_ID; // RL6 RL17
    wire op_ok = cdb_opcode == sir_pkg::SIR_OP_INQUIRY; // RL1
    sir_pkg::sir_sel_t sel_dec;
    assign sel_dec = !cdb_evpd ? sir_pkg::SIR_SEL_STD : // RL4
        (cdb_page == sir_pkg::SIR_PG_SUP) ? sir_pkg::SIR_SEL_SUP : // RL5
        (cdb_page == sir_pkg::SIR_PG_SER) ? sir_pkg::SIR_SEL_SER :
        sir_pkg::SIR_SEL_ID; // RL6
    wire [7:0] limit_dec = min8(cdb_alloc, sel_len(sel_dec)); // RL3 RL16

    // byte assembly: fixed fields override the loaded image
    wire [7:0] hdr_byte = {sir_pkg::SIR_QUAL, sir_pkg::SIR_DTYPE}; // RL12 RL13
    wire in_name = idx_reg >= sir_pkg::SIR_B_NAME_LO && idx_reg <= sir_pkg::SIR_B_NAME_HI;
    wire in_tag = idx_reg >= sir_pkg::SIR_B_TAG_LO && idx_reg <= sir_pkg::SIR_B_TAG_HI;
    wire [2:0] tag_pos = 3'(idx_reg - sir_pkg::SIR_B_TAG_LO);
    wire [7:0] tag_byte = FIRMWARE_IMAGE_TAG[8'(7 - tag_pos) * 8 +: 8];
    // unset name bytes become spaces, so short names need no padding in the image
    wire [7:0] name_byte = (mem_rd == sir_pkg::SIR_ZERO) ? sir_pkg::SIR_SPACE : mem_rd; // RL8
    logic [7:0] std_byte;
    logic [7:0] sup_byte;
    logic [7:0] vpd_byte;
    logic [7:0] out_byte;
    always_comb begin
        if (idx_reg == sir_pkg::SIR_B_HDR) std_byte = hdr_byte; // RL7
        else if (idx_reg == sir_pkg::SIR_B_VER) std_byte = VERSION_BYTE; // RL7
        else if (idx_reg == sir_pkg::SIR_B_FMT) std_byte = FORMAT_BYTE; // RL7
        else if (idx_reg == sir_pkg::SIR_B_ADDLEN) std_byte = sir_pkg::SIR_STD_ADDLEN; // RL7
        else if (in_name) std_byte = name_byte; // RL8
        else if (in_tag) std_byte = tag_byte; // RL9
        else std_byte = mem_rd;
    end
    always_comb begin
        case (idx_reg)
            sir_pkg::SIR_B_HDR: sup_byte = hdr_byte; // RL10
            sir_pkg::SIR_B_PLEN: sup_byte = sir_pkg::SIR_SUP_PLEN; // RL10 RL14
            sir_pkg::SIR_B_LIST0: sup_byte = sir_pkg::SIR_PG_SUP; // RL11 RL14
            sir_pkg::SIR_B_LIST1: sup_byte = sir_pkg::SIR_PG_SER; // RL11 RL14
            sir_pkg::SIR_B_LIST2: sup_byte = sir_pkg::SIR_PG_ID; // RL11 RL14
            default: sup_byte = sir_pkg::SIR_ZERO; // RL10
        endcase
    end
    wire vpd_id = sel_reg == sir_pkg::SIR_SEL_ID;
    always_comb begin
        case (idx_reg)
            sir_pkg::SIR_B_HDR: vpd_byte = hdr_byte;
            sir_pkg::SIR_B_PAGE: vpd_byte = vpd_id ? sir_pkg::SIR_PG_ID : sir_pkg::SIR_PG_SER;
            sir_pkg::SIR_B_RSV: vpd_byte = sir_pkg::SIR_ZERO;
            sir_pkg::SIR_B_PLEN: vpd_byte = vpd_id ? sir_pkg::SIR_ID_PLEN : sir_pkg::SIR_SER_PLEN; // RL15
            default: vpd_byte = mem_rd;
        endcase
    end
    always_comb begin
        case (sel_reg)
            sir_pkg::SIR_SEL_STD: out_byte = std_byte;
            sir_pkg::SIR_SEL_SUP: out_byte = sup_byte;
            default: out_byte = vpd_byte;
        endcase
    end

    // register bus decode
    wire aw_take = s_axi_awvalid && !aw_full_reg;
    wire w_take = s_axi_wvalid && !w_full_reg;
    wire wr_go = aw_full_reg && w_full_reg && !bvalid_reg;
    wire ar_take = s_axi_arvalid && !rvalid_reg;
    wire [7:0] ar_off = s_axi_araddr[7:0];
    wire wr_ctrl = wr_go && aw_addr_reg == sir_pkg::SIR_REG_CTRL;
    wire wr_status = wr_go && aw_addr_reg == sir_pkg::SIR_REG_STATUS;
    wire wr_cdb_lo = wr_go && aw_addr_reg == sir_pkg::SIR_REG_CDB_LO;
    wire wr_cdb_hi = wr_go && aw_addr_reg == sir_pkg::SIR_REG_CDB_HI;
    wire wr_maddr = wr_go && aw_addr_reg == sir_pkg::SIR_REG_MEM_ADDR;
    wire wr_mdata = wr_go && aw_addr_reg == sir_pkg::SIR_REG_MEM_DATA && w_strb_reg[0];
    wire wr_known = wr_ctrl || wr_status || wr_cdb_lo || wr_cdb_hi || wr_maddr ||
        aw_addr_reg == sir_pkg::SIR_REG_MEM_DATA;
    wire busy = state_reg != sir_pkg::SIR_IDLE;
    // start while busy is dropped; software polls busy first
    wire start = wr_ctrl && w_strb_reg[0] && w_data_reg[0] && !busy;
    wire done_clr = wr_status && w_strb_reg[0] && w_data_reg[sir_pkg::SIR_ST_DONE];
    wire [31:0] status_word = {16'h0000, sent_reg, 4'h0, badop_reg, check_reg, done_reg, busy};
    logic [31:0] rd_word;
    logic rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        case (ar_off)
            sir_pkg::SIR_REG_CTRL: rd_word = 32'h0000_0000;
            sir_pkg::SIR_REG_STATUS: rd_word = status_word;
            sir_pkg::SIR_REG_CDB_LO: rd_word = cdb_lo_reg;
            sir_pkg::SIR_REG_CDB_HI: rd_word = {16'h0000, cdb_hi_reg};
            sir_pkg::SIR_REG_MEM_ADDR: rd_word = {24'h000000, mem_addr_reg};
            sir_pkg::SIR_REG_MEM_DATA: rd_word = 32'h0000_0000;
            default: begin
                rd_word = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end
    function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw,
        input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            old[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
        lanes = old;
    endfunction
    wire [31:0] cdb_hi_new = lanes({16'h0000, cdb_hi_reg}, w_data_reg, w_strb_reg);

    assign s_axi_awready = !aw_full_reg;
    assign s_axi_wready = !w_full_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= sir_pkg::SIR_RESP_OK;
        end else begin
            if (aw_take) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
            end else if (wr_go) begin
                aw_full_reg <= 1'b0;
            end
            if (w_take) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (wr_go) begin
                w_full_reg <= 1'b0;
            end
            if (wr_go) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_known ? sir_pkg::SIR_RESP_OK : sir_pkg::SIR_RESP_ERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= sir_pkg::SIR_RESP_OK;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= rd_hit ? sir_pkg::SIR_RESP_OK : sir_pkg::SIR_RESP_ERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cdb_lo_reg <= 32'h0000_0000;
            cdb_hi_reg <= 16'h0000;
            mem_addr_reg <= 8'h00;
        end else begin
            if (wr_cdb_lo && !busy) cdb_lo_reg <= lanes(cdb_lo_reg, w_data_reg, w_strb_reg);
            if (wr_cdb_hi && !busy) cdb_hi_reg <= cdb_hi_new[15:0];
            if (wr_maddr && w_strb_reg[0]) mem_addr_reg <= w_data_reg[7:0];
            else if (wr_mdata) mem_addr_reg <= mem_addr_reg + 8'h01;
        end
    end

    // transfer engine: one byte per fetch and push pair
    wire push_ok = state_reg == sir_pkg::SIR_PUSH && fifo_in_ready;
    wire last_byte = idx_reg == limit_reg - 8'h01; // RL16
    always_comb begin
        case (state_reg)
            sir_pkg::SIR_IDLE: begin
                if (start && op_ok && page_ok && limit_dec != 8'h00) state_next = sir_pkg::SIR_FETCH;
                else if (start) state_next = sir_pkg::SIR_FINISH; // RL16 RL17
                else state_next = sir_pkg::SIR_IDLE;
            end
            sir_pkg::SIR_FETCH: state_next = sir_pkg::SIR_PUSH;
            sir_pkg::SIR_PUSH: begin
                if (push_ok && last_byte) state_next = sir_pkg::SIR_FINISH; // RL16
                else if (push_ok) state_next = sir_pkg::SIR_FETCH;
                else state_next = sir_pkg::SIR_PUSH;
            end
            sir_pkg::SIR_FINISH: state_next = sir_pkg::SIR_IDLE;
            default: state_next = sir_pkg::SIR_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= sir_pkg::SIR_IDLE;
            sel_reg <= sir_pkg::SIR_SEL_STD;
            idx_reg <= 8'h00;
            limit_reg <= 8'h00;
            sent_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (start) begin
                sel_reg <= sel_dec;
                limit_reg <= limit_dec; // RL3 RL16
                idx_reg <= 8'h00;
                sent_reg <= 8'h00;
            end else if (push_ok) begin
                idx_reg <= idx_reg + 8'h01;
                sent_reg <= sent_reg + 8'h01;
            end
        end
    end

    // sticky flags: a setting event beats a same-cycle clear
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            done_reg <= 1'b0;
            check_reg <= 1'b0;
            badop_reg <= 1'b0;
        end else begin
            if (state_reg == sir_pkg::SIR_FINISH) done_reg <= 1'b1;
            else if (done_clr || start) done_reg <= 1'b0;
            if (start) begin
                check_reg <= op_ok && !page_ok; // RL17
                badop_reg <= !op_ok; // RL1
            end
        end
    end

    sir_mem #(
        .AW(8)
    ) u_mem (
        .clock(clock),
        .wr_en(wr_mdata),
        .wr_addr(mem_addr_reg),
        .wr_data(w_data_reg[7:0]),
        .rd_addr(8'(sel_base(sel_reg) + idx_reg)),
        .rd_data(mem_rd)
    );

    sir_fifo #(
        .WIDTH(9),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst(rst),
        .in_data({last_byte, out_byte}),
        .in_valid(state_reg == sir_pkg::SIR_PUSH),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out),
        .out_valid(resp_valid),
        .out_ready(resp_ready)
    );
    assign resp_data = fifo_out[7:0];
    assign resp_last = fifo_out[8];
endmodule

// ===== tb/sir_chk.sv
`timescale 1ns/100ps
module sir_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] resp_data,
    input wire logic resp_last,
    input wire logic resp_valid,
    input wire logic resp_ready
);
    logic [7:0] idx_reg;
    wire logic hs = resp_valid && resp_ready;
    // byte index inside the current response, back to 0 after last
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            idx_reg <= 8'h00;
        else if (hs)
            idx_reg <= resp_last ? 8'h00 : idx_reg + 8'h01;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bvalid dropped early");
    a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rvalid dropped early");
    a_arready_free: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("arready not inverse of rvalid");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_stream_holds: assert property (resp_valid && !resp_ready |=> resp_valid && $stable({resp_data, resp_last}))
        else $error("stream byte changed while stalled");
    a_qual_zero: assert property (hs && idx_reg == 8'h00 |-> resp_data[7:5] == 3'h0)
        else $error("qualifier not zero");
    a_dtype_seq: assert property (hs && idx_reg == 8'h00 |-> resp_data[4:0] == 5'h01)
        else $error("device type wrong");
    a_len_bound: assert property (hs |-> idx_reg < 8'h6A)
        else $error("response too long");
endmodule
bind sir_top sir_chk sir_chk_inst (.clock(clock), .rst(rst), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .resp_data(resp_data), .resp_last(resp_last),
    .resp_valid(resp_valid), .resp_ready(resp_ready));

// ===== tb/sir_sink.sv
`timescale 1ns/100ps
module sir_sink (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] resp_data,
    input wire logic resp_last,
    input wire logic resp_valid,
    output logic resp_ready = 1'b0
);
    logic [7:0] got [0:127];
    int cnt = 0;
    int last_at = -1;
    logic [4:0] phase = 5'h00;
    // long stalls so the fifo fills and pushes back on the engine
    always @(posedge clock) begin
        phase <= rst ? 5'h00 : phase + 5'h01;
        resp_ready <= !rst && phase >= 5'h1B;
        if (!rst && resp_valid && resp_ready) begin
            got[cnt] <= resp_data;
            if (resp_last)
                last_at <= cnt;
            cnt <= cnt + 1;
        end
    end
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    localparam logic [7:0] VER = 8'h04;
    localparam logic [7:0] FMT = 8'h22;
    localparam logic [63:0] NAME = 64'h5441_5045_554E_4954;
    // tag value is arbitrary
    localparam logic [63:0] TAG = 64'h5A31_3233_3435_3637;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, resp_last, resp_valid, resp_ready;
    logic [1:0] bresp, rresp, rr;
    logic [7:0] resp_data;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    sir_top #(.VERSION_BYTE(VER), .FORMAT_BYTE(FMT), .FIRMWARE_IMAGE_TAG(TAG), .FIFO_DEPTH(8)) sir_top_inst (
        .clock(clock), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .resp_data(resp_data), .resp_last(resp_last),
        .resp_valid(resp_valid), .resp_ready(resp_ready));
    sir_sink sir_sink_inst (.clock(clock), .rst(rst), .resp_data(resp_data), .resp_last(resp_last),
        .resp_valid(resp_valid), .resp_ready(resp_ready));
    initial begin
        forever #10 clock = ~clock;
    end
    task automatic summarize();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            summarize();
        end
    end
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic axi_wr(logic [7:0] a, logic [31:0] d);
        awaddr <= {24'h0, a};
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        check("bresp", bresp, 2'h0);
        bready <= 1'b0;
        @(posedge clock);
    endtask
    task automatic axi_rd(logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= {24'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            if (arready === 1'b1)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clock);
    endtask
    // name zone holds 00h padding so the space fill shows
    function automatic logic [7:0] mem_val(int m);
        if (m >= 16 && m < 24)
            return NAME[8*(23-m) +: 8];
        if (m >= 24 && m < 32)
            return 8'h00;
        return m[7:0] ^ 8'h5A;
    endfunction
    function automatic logic [7:0] exp_byte(int sel, int i);
        logic [7:0] sup [0:6];
        sup = '{8'h01, 8'h00, 8'h00, 8'h03, 8'h00, 8'h80, 8'h83};
        if (sel == 1)
            return sup[i];
        if (i == 0)
            return 8'h01;
        if (sel == 0) begin
            if (i == 2)
                return VER;
            if (i == 3)
                return FMT;
            if (i == 4)
                return 8'h65;
            if (i >= 24 && i < 32)
                return 8'h20;
            if (i >= 36 && i < 44)
                return TAG[8*(43-i) +: 8];
            return mem_val(i);
        end
        if (i == 1)
            return sel == 2 ? 8'h80 : 8'h83;
        if (i == 2)
            return 8'h00;
        if (i == 3)
            return sel == 2 ? 8'h0A : 8'h3E;
        return mem_val((sel == 2 ? 128 : 160) + i);
    endfunction
    task automatic run(logic [7:0] op, logic ev, logic [7:0] pg, logic [7:0] al, int n, int sel, logic [1:0] err);
        int k;
        axi_wr(8'h08, {8'h00, pg, 7'h00, ev, op});
        axi_wr(8'h0C, {24'h0, al});
        sir_sink_inst.cnt = 0;
        sir_sink_inst.last_at = -1;
        axi_wr(8'h00, 32'h1);
        k = 0;
        do begin
            axi_rd(8'h04, rd, rr);
            k++;
        end while (rd[1:0] !== 2'b10 && k < 400);
        for (k = 0; k < 200 && resp_valid !== 1'b0; k++)
            @(posedge clock);
        check("status", {22'h0, rd[15:8], rd[3:2]}, {22'h0, n[7:0], err});
        check("count", sir_sink_inst.cnt, n);
        check("last", sir_sink_inst.last_at, n - 1);
        for (k = 0; k < n; k++)
            check("byte", sir_sink_inst.got[k], exp_byte(sel, k));
        $display("done op %h evpd %b page %h alloc %h", op, ev, pg, al);
    endtask
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        axi_rd(8'h04, rd, rr);
        check("status_rst", rd, 32'h0);
        axi_rd(8'h18, rd, rr);
        check("unmapped", {rd[29:0], rr}, {30'h0, 2'h2});
        axi_wr(8'h10, 32'h0);
        for (int m = 0; m < 226; m++)
            axi_wr(8'h14, {24'h0, mem_val(m)});
        run(8'h12, 1'b0, 8'h55, 8'hFF, 106, 0, 2'b00);
        run(8'h12, 1'b0, 8'h00, 8'h00, 0, 0, 2'b00);
        run(8'h12, 1'b0, 8'h83, 8'h2C, 44, 0, 2'b00);
        run(8'h12, 1'b1, 8'h00, 8'h07, 7, 1, 2'b00);
        run(8'h12, 1'b1, 8'h00, 8'hFF, 7, 1, 2'b00);
        run(8'h12, 1'b1, 8'h80, 8'h0E, 14, 2, 2'b00);
        run(8'h12, 1'b1, 8'h83, 8'h42, 66, 3, 2'b00);
        run(8'h12, 1'b1, 8'h83, 8'h41, 65, 3, 2'b00);
        run(8'h12, 1'b1, 8'h81, 8'hFF, 0, 0, 2'b01);
        run(8'h13, 1'b0, 8'h00, 8'hFF, 0, 0, 2'b10);
        axi_wr(8'h04, 32'h2);
        axi_rd(8'h04, rd, rr);
        check("done_clr", rd[3:0], 4'h8);
        summarize();
    end
endmodule
